// ### design/fpm_front_panel.sv
`timescale 1ns/1ps
module fpm_front_panel #(
   parameter int NPORT = fpm_pkg::NPORT_DEF,
   parameter int NDIN = fpm_pkg::NDIN_DEF,
   parameter logic HAS_DIN = 1'b1,
   parameter logic [NPORT-1:0] FIBER_MASK = '0,
   parameter int STARTUP_CYC = fpm_pkg::STARTUP_CYC,
   parameter int HOLD_RESET_CYC = fpm_pkg::HOLD_RESET_CYC,
   parameter int HOLD_MASK_CYC = fpm_pkg::HOLD_MASK_CYC,
   parameter int HOLD_CONFIRM_CYC = fpm_pkg::HOLD_CONFIRM_CYC,
   parameter int DEBOUNCE_CYC = fpm_pkg::DEBOUNCE_CYC,
   parameter int BLINK_SLOT_CYC = fpm_pkg::BLINK_SLOT_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic btn_raw,
   input wire logic stby_sw,
   input wire logic redundancy_manager_switch,
   input wire logic [NPORT-1:0] link_raw,
   input wire logic [NPORT-1:0] sig_ok,
   input wire logic [NPORT-1:0] speed100,
   input wire logic [NPORT-1:0] full_dup,
   input wire logic [NPORT-1:0] rx_act,
   input wire logic [NPORT-1:0] port_stby,
   input wire logic [NPORT-1:0] port_seg,
   input wire logic [NPORT-1:0] port_off,
   input wire logic [NPORT-1:0] port_mirr,
   input wire logic [fpm_pkg::NSUP-1:0] supply_ok,
   input wire logic [NDIN-1:0] din,
   input wire logic din_notify_en,
   output logic [NPORT-1:0] port_led_grn_q,
   output logic [NPORT-1:0] port_led_yel_q,
   output logic [2:0] mode_led_q,
   output logic [NPORT-1:0] mask_port_q,
   output logic [fpm_pkg::NSUP-1:0] mask_sup_q,
   output logic sig_contact_q,
   output logic stby_en_q,
   output logic rm_en_q,
   output logic factory_reset_q,
   output logic fw_load_q,
   output logic [NDIN-1:0] din_state_q,
   output logic din_change_q
);
   import fpm_pkg::*;
   localparam logic [CNT_W-1:0] RESET_LIM = CNT_W'(HOLD_RESET_CYC - 1);
   localparam logic [CNT_W-1:0] MASK_LIM = CNT_W'(HOLD_MASK_CYC - 1);
   localparam logic [CNT_W-1:0] CONFIRM_LIM = CNT_W'(HOLD_CONFIRM_CYC - 1);
   localparam logic [CNT_W-1:0] START_LIM = CNT_W'(STARTUP_CYC - 1);

   logic btn_db, btn_prev_q, flash;
   logic [FLASH_CODES:1] code;
   logic [NPORT-1:0] link_eff;
   logic port_fault, sup_fault;

   //////////////////////////////////////////////////////////////////////////
   // Button conditioning and flash patterns

   fpm_debounce #(.CYC(DEBOUNCE_CYC)) u_db (
      .clk(clk),
      .nrst(nrst),
      .raw(btn_raw),
      .level_q(btn_db)
   );

   fpm_blink #(.SLOT_CYC(BLINK_SLOT_CYC)) u_blink (
      .clk(clk),
      .nrst(nrst),
      .flash_q(flash),
      .code_q(code)
   );

   //////////////////////////////////////////////////////////////////////////
   // Link qualification and fault sum

   // A fiber port counts as linked only with light and at 100 Mbps
   assign link_eff = link_raw & (~FIBER_MASK | (sig_ok & speed100));
   assign port_fault = |(mask_port_q & ~link_eff);
   assign sup_fault = |(mask_sup_q & ~supply_ok);

   //////////////////////////////////////////////////////////////////////////
   // Start-up window, switch straps and button sequencer

   fpm_state_t st_q, st_d;
   fpm_mode_t mode_q, mode_d;
   logic [CNT_W-1:0] hold_q, hold_d, start_q, start_d;
   logic starting_q, starting_d, sampled_q, sampled_d;
   logic stby_en_d, rm_en_d, reset_d, capture;
   logic [NPORT-1:0] mask_port_d;
   logic [NSUP-1:0] mask_sup_d;

   // Straps are caught after reset release and again after a button factory reset, never otherwise
   always_comb begin
      sampled_d = 1'b1;
      stby_en_d = stby_en_q;
      rm_en_d = rm_en_q;
      if (!sampled_q) begin
         stby_en_d = stby_sw;
         rm_en_d = redundancy_manager_switch;
      end
      if (factory_reset_q) begin
         sampled_d = 1'b0;
      end
      starting_d = starting_q && (start_q != START_LIM);
      start_d = starting_q ? start_q + 1'b1 : start_q;
   end

   // Hold timing runs only while the debounced button stays down
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      hold_d = hold_q;
      reset_d = 1'b0;
      capture = 1'b0;
      case (st_q)
         ST_IDLE: begin
            hold_d = '0;
            if (btn_db && !btn_prev_q) begin
               st_d = starting_q ? ST_FW_HELD : ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!btn_db) begin
               st_d = ST_IDLE;
               if (hold_q <= ((mode_q == MD_PORT) ? RESET_LIM : MASK_LIM)) begin
                  mode_d = fpm_next_mode(mode_q, HAS_DIN);
               end
            end else if (mode_q == MD_PORT && hold_q == RESET_LIM) begin
               st_d = ST_ARMED;
               hold_d = '0;
            end else if (mode_q == MD_MASK && hold_q == MASK_LIM) begin
               st_d = ST_ARMED;
               hold_d = '0;
            end else if (hold_q <= RESET_LIM) begin
               hold_d = hold_q + 1'b1;
            end
         end
         ST_ARMED: begin
            if (!btn_db) begin
               st_d = ST_IDLE;
            end else if (hold_q == CONFIRM_LIM) begin
               st_d = ST_WAIT;
               reset_d = (mode_q == MD_PORT);
               capture = (mode_q == MD_MASK);
            end else begin
               hold_d = hold_q + 1'b1;
            end
         end
         ST_WAIT: begin
            if (!btn_db) begin
               st_d = ST_IDLE;
            end
         end
         ST_FW_HELD: begin
            if (!btn_db) begin
               st_d = ST_FW_RUN;
            end
         end
         ST_FW_RUN: begin
            if (btn_db) begin
               st_d = ST_WAIT;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (reset_d) begin
         mode_d = MD_PORT;
      end
   end

   // Mask: factory default on reset, snapshot on capture
   always_comb begin
      mask_port_d = mask_port_q;
      mask_sup_d = mask_sup_q;
      if (reset_d) begin
         mask_port_d = {NPORT{MASK_RST_BIT}};
         mask_sup_d = {NSUP{MASK_RST_BIT}};
      end else if (capture) begin
         mask_port_d = link_eff;
         mask_sup_d = supply_ok;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         mode_q <= MD_PORT;
         hold_q <= '0;
         start_q <= '0;
         starting_q <= 1'b1;
         sampled_q <= 1'b0;
         stby_en_q <= 1'b0;
         rm_en_q <= 1'b0;
         factory_reset_q <= 1'b0;
         btn_prev_q <= 1'b0;
         mask_port_q <= {NPORT{MASK_RST_BIT}};
         mask_sup_q <= {NSUP{MASK_RST_BIT}};
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         hold_q <= hold_d;
         start_q <= start_d;
         starting_q <= starting_d;
         sampled_q <= sampled_d;
         stby_en_q <= stby_en_d;
         rm_en_q <= rm_en_d;
         factory_reset_q <= reset_d;
         btn_prev_q <= btn_db;
         mask_port_q <= mask_port_d;
         mask_sup_q <= mask_sup_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Displays, signaling contact and digital inputs

   logic [NPORT-1:0] grn_d, yel_d;
   logic [2:0] mode_led_d;
   logic fw_load_d, contact_d, din_change_d;
   logic [NDIN-1:0] din_state_d;

   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi++) begin : g_port
         logic ps_grn;
         // Flash codes win over steady green; no link leaves the LED dark
         always_comb begin
            if (!link_eff[gi]) ps_grn = 1'b0;
            else if (port_stby[gi]) ps_grn = code[1];
            else if (port_seg[gi]) ps_grn = code[2];
            else if (port_off[gi]) ps_grn = code[3];
            else if (port_mirr[gi]) ps_grn = code[4];
            else ps_grn = 1'b1;
         end
         always_comb begin
            yel_d[gi] = 1'b0;
            case (mode_q)
               MD_PORT: begin
                  grn_d[gi] = ps_grn;
                  yel_d[gi] = link_eff[gi] && rx_act[gi];
               end
               MD_SPEED: grn_d[gi] = link_eff[gi] && speed100[gi];
               MD_DUPLEX: grn_d[gi] = link_eff[gi] && full_dup[gi];
               MD_MASK: grn_d[gi] = mask_port_q[gi];
               MD_DIN: grn_d[gi] = (gi < NDIN) ? din[gi % NDIN] : 1'b0;
               default: grn_d[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   // Mode LEDs carry the mode code; flashing states show all of them blinking
   always_comb begin
      fw_load_d = (st_d == ST_FW_HELD) || (st_d == ST_FW_RUN);
      if (fw_load_d || st_d == ST_ARMED) begin
         mode_led_d = {3{flash}};
      end else begin
         mode_led_d = mode_d;
      end
      if (!HAS_DIN) begin
         mode_led_d[2] = 1'b0;
      end
      contact_d = port_fault || sup_fault;
      din_state_d = din;
      din_change_d = din_notify_en && (din != din_state_q);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_led_grn_q <= '0;
         port_led_yel_q <= '0;
         mode_led_q <= MODE_LED_OFF;
         fw_load_q <= 1'b0;
         sig_contact_q <= 1'b0;
         din_state_q <= '0;
         din_change_q <= 1'b0;
      end else begin
         port_led_grn_q <= grn_d;
         port_led_yel_q <= yel_d;
         mode_led_q <= mode_led_d;
         fw_load_q <= fw_load_d;
         sig_contact_q <= contact_d;
         din_state_q <= din_state_d;
         din_change_q <= din_change_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks

   contact_set_a: assert property (@(posedge clk) disable iff (!nrst)
      port_fault |=> sig_contact_q) else $error("monitored link loss missed");
   contact_excl_a: assert property (@(posedge clk) disable iff (!nrst)
      (!port_fault && !sup_fault) |=> !sig_contact_q) else $error("contact without fault");
   supply_fault_a: assert property (@(posedge clk) disable iff (!nrst)
      sup_fault |=> sig_contact_q) else $error("monitored supply loss missed");
   mask_led_a: assert property (@(posedge clk) disable iff (!nrst)
      (mode_q == MD_MASK) |=> port_led_grn_q == $past(mask_port_q))
      else $error("mask display wrong");
   din_led_a: assert property (@(posedge clk) disable iff (!nrst)
      (mode_q == MD_DIN && st_d == ST_IDLE && mode_d == MD_DIN)
      |=> mode_led_q == 3'h4 && port_led_grn_q[0] == $past(din[0]))
      else $error("input display wrong");
   no_din_led_a: assert property (@(posedge clk) disable iff (!nrst)
      !HAS_DIN |-> !mode_led_q[2] && mode_q != MD_DIN) else $error("input mode present");
   strap_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (sampled_q && $past(sampled_q)) |-> $stable(stby_en_q) && $stable(rm_en_q))
      else $error("switch resampled while running");
   mode_step_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == ST_HOLD && !btn_db && hold_q < MASK_LIM)
      |=> mode_q == fpm_next_mode($past(mode_q), HAS_DIN)) else $error("press not advanced");
   reset_dflt_a: assert property (@(posedge clk) disable iff (!nrst)
      factory_reset_q |-> mode_q == MD_PORT && &mask_port_q && &mask_sup_q)
      else $error("reset did not restore defaults");
   capture_a: assert property (@(posedge clk) disable iff (!nrst)
      capture |=> mask_port_q == $past(link_eff) && mask_sup_q == $past(supply_ok))
      else $error("mask capture wrong");
   fw_enter_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_q == ST_IDLE && starting_q && btn_db && !btn_prev_q) |=> ##1 fw_load_q)
      else $error("firmware load not entered");
   fiber_rate_a: assert property (@(posedge clk) disable iff (!nrst)
      (|(FIBER_MASK & ~speed100)) |-> (FIBER_MASK & ~speed100 & link_eff) == '0)
      else $error("fiber linked at 10");
endmodule : fpm_front_panel

// ### design/fpm_pkg.sv
// Functional notes
// - Fault-mask mode lights a port LED green when that port is monitored.
// - Signaling contact activates when a monitored port has no valid link.
// - Link state of unmonitored ports never affects the signaling contact.
// - Digital-input mode, third mode LED alone, shows inputs green at 1.
// - Third mode LED and digital-input mode exist only on variants with inputs.
// - One switch enables standby, the other activates redundancy manager.
// - Both switches are sampled only at start-up and after a button reset, other changes ignored.
// - Brief press advances the display mode; mode LEDs show current mode.
// - Port-status mode: 3 s hold flashes mode LEDs, 2 s more resets.
// - Button reset returns every setting to its factory default.
// - Fault-mask mode: 2 s hold flashes, 2 s more captures links and supplies.
// - Press during 20 s start-up enters firmware load; next press leaves.
// - Fiber ports detect a cable break and drop their port status.
// - Fiber ports run only at 100 Mbps, never link at 10 Mbps.
// - Present digital input states are readable for management gets.
// - When enabled, an input change raises a notification event.
// - Port-status LEDs: dark, steady, or one to four flashes; yellow receive.
package fpm_pkg;
   localparam int CLK_KHZ = 40_000;
   localparam int STARTUP_MS = 20_000;
   localparam int HOLD_RESET_MS = 3_000;
   localparam int HOLD_MASK_MS = 2_000;
   localparam int HOLD_CONFIRM_MS = 2_000;
   localparam int DEBOUNCE_MS = 20;
   localparam int BLINK_SLOT_MS = 125;
   localparam int STARTUP_CYC = STARTUP_MS * CLK_KHZ;
   localparam int HOLD_RESET_CYC = HOLD_RESET_MS * CLK_KHZ;
   localparam int HOLD_MASK_CYC = HOLD_MASK_MS * CLK_KHZ;
   localparam int HOLD_CONFIRM_CYC = HOLD_CONFIRM_MS * CLK_KHZ;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
   localparam int BLINK_SLOT_CYC = BLINK_SLOT_MS * CLK_KHZ;
   localparam int CNT_W = 30;
   localparam int NPORT_DEF = 8;
   localparam int NDIN_DEF = 4;
   localparam int NSUP = 2;
   localparam int BLINK_SLOTS = 10;
   localparam int FLASH_CODES = 4;
   localparam logic MASK_RST_BIT = 1'b1;
   localparam logic [2:0] MODE_LED_OFF = 3'h0;

   typedef enum logic [2:0] {
      MD_PORT = 3'b000,
      MD_SPEED = 3'b001,
      MD_DUPLEX = 3'b010,
      MD_MASK = 3'b011,
      MD_DIN = 3'b100
   } fpm_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HOLD = 3'b001,
      ST_ARMED = 3'b010,
      ST_WAIT = 3'b011,
      ST_FW_HELD = 3'b100,
      ST_FW_RUN = 3'b101
   } fpm_state_t;

   // Mode ring; the input mode is skipped on variants without inputs
   function automatic fpm_mode_t fpm_next_mode(input fpm_mode_t m, input logic has_din);
      case (m)
         MD_PORT: fpm_next_mode = MD_SPEED;
         MD_SPEED: fpm_next_mode = MD_DUPLEX;
         MD_DUPLEX: fpm_next_mode = MD_MASK;
         MD_MASK: fpm_next_mode = has_din ? MD_DIN : MD_PORT;
         default: fpm_next_mode = MD_PORT;
      endcase
   endfunction : fpm_next_mode
endpackage : fpm_pkg

// ### design/fpm_debounce.sv
`timescale 1ns/1ps
module fpm_debounce #(
   parameter int CYC = fpm_pkg::DEBOUNCE_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic raw,
   output logic level_q
);
   import fpm_pkg::*;
   localparam int W = $clog2(CYC + 1);
   localparam logic [W-1:0] LIM = W'(CYC - 1);

   logic sync1_q, sync2_q, level_d;
   logic [W-1:0] cnt_q, cnt_d;

   // Level only follows after the input stayed different for CYC cycles
   always_comb begin
      level_d = level_q;
      cnt_d = '0;
      if (sync2_q != level_q) begin
         cnt_d = cnt_q + 1'b1;
         if (cnt_q == LIM) begin
            level_d = sync2_q;
            cnt_d = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         level_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
         level_q <= level_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : fpm_debounce

// ### design/fpm_blink.sv
`timescale 1ns/1ps
module fpm_blink #(
   parameter int SLOT_CYC = fpm_pkg::BLINK_SLOT_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   output logic flash_q,
   output logic [fpm_pkg::FLASH_CODES:1] code_q
);
   import fpm_pkg::*;
   localparam int W = $clog2(SLOT_CYC + 1);
   localparam logic [W-1:0] LIM = W'(SLOT_CYC - 1);
   localparam logic [3:0] LAST = 4'(BLINK_SLOTS - 1);
   localparam logic [3:0] HALF = 4'(BLINK_SLOTS / 2);

   logic [W-1:0] cnt_q, cnt_d;
   logic [3:0] slot_q, slot_d;
   logic flash_d;
   logic [FLASH_CODES:1] code_d;

   // Period of BLINK_SLOTS slots; code n lights in the first n even slots
   always_comb begin
      cnt_d = cnt_q + 1'b1;
      slot_d = slot_q;
      if (cnt_q == LIM) begin
         cnt_d = '0;
         slot_d = (slot_q == LAST) ? 4'h0 : slot_q + 4'h1;
      end
      flash_d = (slot_d < HALF);
      for (int n = 1; n <= FLASH_CODES; n++) begin
         code_d[n] = !slot_d[0] && (slot_d < 4'(2 * n));
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
         slot_q <= 4'h0;
         flash_q <= 1'b0;
         code_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         slot_q <= slot_d;
         flash_q <= flash_d;
         code_q <= code_d;
      end
   end
endmodule : fpm_blink

// ### testbench/fpm_operator.sv
`timescale 1ns/1ps
module fpm_operator (
   input wire logic clk,
   output logic btn_raw,
   output logic stby_sw,
   output logic redundancy_manager_switch
);
   // Button released, standby on, redundancy manager off at power-up
   initial begin
      btn_raw = 1'b0;
      stby_sw = 1'b1;
      redundancy_manager_switch = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // Hold the button n cycles; a one-cycle press stands for bounce
   task automatic press(input int n);
      @(posedge clk);
      #2 btn_raw = 1'b1;
      repeat (n) @(posedge clk);
      #2 btn_raw = 1'b0;
      // Debounce needs time to see the release before the next press
      repeat (14) @(posedge clk);
      #2;
   endtask : press
   // Switches may move any time; only start-up and a factory reset should notice
   task automatic set_sw(input logic s, input logic r);
      @(posedge clk);
      #2 stby_sw = s;
      redundancy_manager_switch = r;
   endtask : set_sw
endmodule : fpm_operator

// ### testbench/tb_fpm_front_panel.sv
`timescale 1ns/1ps
module tb_fpm_front_panel;
   import fpm_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic btn_raw, stby_sw, redundancy_manager_switch;
   logic [3:0] link_raw = 4'hf, sig_ok = 4'hf, speed100 = 4'hf, full_dup = 4'h5;
   logic [3:0] rx_act = 4'h6, din = 4'h0;
   logic [3:0] port_stby = 4'h0, port_seg = 4'h0, port_off = 4'h0, port_mirr = 4'h0;
   logic [1:0] supply_ok = 2'h3;
   logic din_notify_en = 1'b0;
   logic [3:0] grn, yel, mask_port, din_state;
   logic [2:0] mode;
   logic [1:0] mask_sup, seen;
   logic contact, stby_en, rm_en, fac_rst, fw_load, din_chg, prev;
   int miscompares = 0;
   int n_compared = 0;
   int rst_cnt = 0;
   int cnt;
   fpm_mode_t ring [5] = '{MD_SPEED, MD_DUPLEX, MD_MASK, MD_DIN, MD_PORT};
   logic [3:0] view [5] = '{4'h3, 4'h5, 4'hf, 4'ha, 4'h7};

   // Short counts keep the long-press and start-up spans cheap to run
   fpm_front_panel #(.NPORT(4), .NDIN(4), .FIBER_MASK(4'h8), .STARTUP_CYC(200),
      .HOLD_RESET_CYC(30), .HOLD_MASK_CYC(20), .HOLD_CONFIRM_CYC(20), .DEBOUNCE_CYC(4),
      .BLINK_SLOT_CYC(2)) u_fpm_front_panel (
      .clk(clk), .nrst(nrst), .btn_raw(btn_raw), .stby_sw(stby_sw),
      .redundancy_manager_switch(redundancy_manager_switch), .link_raw(link_raw),
      .sig_ok(sig_ok), .speed100(speed100), .full_dup(full_dup), .rx_act(rx_act),
      .port_stby(port_stby), .port_seg(port_seg), .port_off(port_off),
      .port_mirr(port_mirr), .supply_ok(supply_ok), .din(din),
      .din_notify_en(din_notify_en), .port_led_grn_q(grn), .port_led_yel_q(yel),
      .mode_led_q(mode), .mask_port_q(mask_port), .mask_sup_q(mask_sup),
      .sig_contact_q(contact), .stby_en_q(stby_en), .rm_en_q(rm_en),
      .factory_reset_q(fac_rst), .fw_load_q(fw_load), .din_state_q(din_state),
      .din_change_q(din_chg));

   fpm_operator u_fpm_operator (.clk(clk), .btn_raw(btn_raw), .stby_sw(stby_sw),
      .redundancy_manager_switch(redundancy_manager_switch));

   always #12.5 clk = ~clk;

   // Pulses are one cycle wide; count them at the falling edge, where they have settled
   always @(negedge clk) begin
      if (fac_rst === 1'b1) rst_cnt++;
   end
   ////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick

   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Navigation: short presses until the wanted mode shows, then a check that it does
   task automatic goto(input fpm_mode_t m);
      for (int i = 0; i < 6 && mode !== m; i++) u_fpm_operator.press(8);
      chk(4'(mode), 4'(m));
   endtask : goto

   task automatic results;
      $display("compared=%0d miscompares=%0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   // Watchdog sized well past the under two thousand cycles the tests need
   initial begin
      #200us;
      miscompares++;
      results();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      tick(2);
      nrst = 1'b1;
      tick(3);
      chk(4'(stby_en), 4'h1);
      chk(4'(rm_en), 4'h0);
      u_fpm_operator.set_sw(1'b0, 1'b1);
      u_fpm_operator.press(8);
      chk(4'(fw_load), 4'h1);
      seen = 2'h0;
      repeat (40) begin
         tick(1);
         seen = seen | {mode === 3'h7, mode === 3'h0};
      end
      chk(4'(seen), 4'h3);
      u_fpm_operator.press(8);
      chk(4'(fw_load), 4'h0);
      chk(4'(stby_en), 4'h1);
      chk(4'(rm_en), 4'h0);
      tick(260);
      chk(4'(mode), 4'(MD_PORT));
      din_notify_en = 1'b1;
      din = 4'h3;
      seen = 2'h0;
      repeat (4) begin
         tick(1);
         seen[0] = seen[0] | din_chg;
      end
      din_notify_en = 1'b0;
      din = 4'ha;
      repeat (4) begin
         tick(1);
         seen[1] = seen[1] | din_chg;
      end
      chk(4'(seen), 4'h1);
      chk(din_state, 4'ha);
      speed100 = 4'h3;
      for (int i = 0; i < 5; i++) begin
         u_fpm_operator.press(8);
         chk(4'(mode), 4'(ring[i]));
         chk(grn, view[i]);
         // Fiber port at 10 Mbps stays dark even when it reports full duplex
         if (ring[i] == MD_DUPLEX) begin
            full_dup = 4'ha;
            tick(3);
            chk(grn, 4'h2);
            full_dup = 4'h5;
         end
      end
      speed100 = 4'hf;
      tick(3);
      chk(4'(contact), 4'h0);
      chk(yel, rx_act);
      rx_act = 4'h9;
      tick(3);
      chk(yel, 4'h9);
      link_raw = 4'he;
      tick(3);
      chk(4'(contact), 4'h1);
      link_raw = 4'hf;
      supply_ok = 2'h1;
      tick(3);
      chk(4'(contact), 4'h1);
      supply_ok = 2'h3;
      sig_ok = 4'h7;
      tick(3);
      chk(grn, 4'h7);
      chk(4'(contact), 4'h1);
      sig_ok = 4'hf;
      goto(MD_MASK);
      link_raw = 4'h5;
      supply_ok = 2'h1;
      u_fpm_operator.press(55);
      chk(mask_port, 4'h5);
      chk(4'(mask_sup), 4'h1);
      chk(4'(contact), 4'h0);
      goto(MD_MASK);
      chk(grn, 4'h5);
      link_raw = 4'h4;
      tick(3);
      chk(4'(contact), 4'h1);
      link_raw = 4'hf;
      supply_ok = 2'h3;
      goto(MD_PORT);
      u_fpm_operator.press(1);
      chk(4'(mode), 4'(MD_PORT));
      u_fpm_operator.press(38);
      chk(4'(rst_cnt), 4'h0);
      chk(4'(mode), 4'(MD_PORT));
      u_fpm_operator.press(65);
      chk(4'(rst_cnt), 4'h1);
      chk(mask_port, 4'hf);
      chk(4'(mask_sup), 4'h3);
      chk(4'(stby_en), 4'h0);
      chk(4'(rm_en), 4'h1);
      chk(4'(mode), 4'(MD_PORT));
      // Ten blink periods, so a cut period at either end cannot mislead
      for (int k = 0; k < 4; k++) begin
         port_stby = {4{k == 0}};
         port_seg = {4{k == 1}};
         port_off = {4{k == 2}};
         port_mirr = {4{k == 3}};
         tick(25);
         cnt = 0;
         repeat (200) begin
            prev = grn[0];
            tick(1);
            if (grn[0] === 1'b1 && prev === 1'b0) cnt++;
         end
         chk(4'((cnt + 5) / 10), 4'(k + 1));
      end
      results();
   end
endmodule : tb_fpm_front_panel
